// >>> hw/cms_call_mode.sv
// cms_call_mode.sv - call mode selection and call/branch execution control
// assumes: a decoder offers one instruction class at a time with its target,
//   software reaches the mode register over a plain 4-bit register port,
//   one machine cycle equals one clk cycle.
`timescale 1ns/1ns
`include "cms_regs.svh"

module cms_call_mode (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // register port
  input  wire logic [3:0]       reg_addr,
  input  wire logic [3:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic [3:0]            reg_rdata,
  // instruction offer
  input  wire logic             op_valid,
  input  wire cms_pkg::cms_op_t op_code,
  input  wire logic [14:0]      op_target,
  output logic                  op_ready,
  // execution results
  output logic                  exec_busy,
  output logic                  exec_done,
  output logic                  exec_illegal,
  output logic                  exec_range_err,
  output logic [1:0]            push_bytes,
  output logic [1:0]            pop_bytes,
  output logic [2:0]            exec_cycles,
  // mode view for the rest of the core
  output logic                  extended_call_mode,
  output logic [1:0]            stack_bank,
  output logic [14:0]           prog_limit,
  output logic [7:0]            stack_ptr
);
  import cms_pkg::*;

  // register state
  logic [3:0]  stack_bank_select_r;
  logic        illegal_flag_r;
  logic        range_flag_r;
  logic [3:0]  rdata_r;

  // sequencer state
  cms_state_t  state_r;
  cms_state_t  state_nxt;
  logic [2:0]  count_r;
  logic        done_r;
  logic        illegal_r;
  logic        range_r;
  logic [1:0]  push_bytes_r;
  logic [1:0]  pop_bytes_r;
  logic [2:0]  exec_cycles_r;

  // lookup results for the offered instruction
  logic [2:0]  tbl_cycles;
  logic [1:0]  tbl_push;
  logic [1:0]  tbl_pop;
  logic        tbl_allowed;
  logic        tbl_is_call;

  // decoded strobes
  logic        take;
  logic        in_range;
  logic        start;
  logic        refuse_illegal;
  logic        refuse_range;
  logic        wr_sbs;
  logic        wr_status;
  logic        clr_illegal;
  logic        clr_range;
  logic        extended;
  logic [14:0] limit;

  // mode and limit decode straight from the register
  assign extended = ~stack_bank_select_r[`CMS_SBS_MODE_BIT];
  assign limit    = extended ? `CMS_PROG_LIMIT_EXTENDED : `CMS_PROG_LIMIT_LEGACY;

  // per-mode instruction table
  cms_op_table u_table (
    .op         (op_code),
    .extended   (extended),
    .cycles     (tbl_cycles),
    .push_bytes (tbl_push),
    .pop_bytes  (tbl_pop),
    .allowed    (tbl_allowed),
    .is_call    (tbl_is_call)
  );

  // an offer is taken only while idle, so a mode write never splits an instruction
  assign take     = op_valid & op_ready;

  // branch and call targets must lie below the reachable limit; returns are not checked
  assign in_range = (op_code == CMS_OP_RETURN) | (op_target < limit);

  // refusals have priority: unavailable first, then out of range
  assign refuse_illegal = take & ~tbl_allowed;
  assign refuse_range   = take & tbl_allowed & ~in_range;
  assign start          = take & tbl_allowed & in_range;

  // register write decode
  assign wr_sbs      = reg_wr & (reg_addr == `CMS_ADDR_STACK_BANK_SELECT);
  assign wr_status   = reg_wr & (reg_addr == `CMS_ADDR_STATUS);
  assign clr_illegal = wr_status & reg_wdata[`CMS_STAT_ILLEGAL_BIT];
  assign clr_range   = wr_status & reg_wdata[`CMS_STAT_RANGE_BIT];

  // mode register: whole nibble written at once, reset lands in legacy mode
  always_ff @(posedge clk) begin
    if (srst) begin
      stack_bank_select_r <= `CMS_SBS_RESET;
    end else if (wr_sbs) begin
      stack_bank_select_r <= reg_wdata;
    end
  end

  // sticky refusal flags, write one to clear; a new refusal beats the clear
  always_ff @(posedge clk) begin
    if (srst) begin
      illegal_flag_r <= 1'b0;
    end else if (refuse_illegal) begin
      illegal_flag_r <= 1'b1;
    end else if (clr_illegal) begin
      illegal_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      range_flag_r <= 1'b0;
    end else if (refuse_range) begin
      range_flag_r <= 1'b1;
    end else if (clr_range) begin
      range_flag_r <= 1'b0;
    end
  end

  // read data one cycle after the strobe, zero otherwise so the bus can be or-ed
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_r <= 4'h0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `CMS_ADDR_STACK_BANK_SELECT: rdata_r <= stack_bank_select_r;
        `CMS_ADDR_STATUS:            rdata_r <= {exec_busy, range_flag_r,
                                                 illegal_flag_r, extended};
        `CMS_ADDR_STACK_PTR_LO:      rdata_r <= stack_ptr[3:0];
        `CMS_ADDR_STACK_PTR_HI:      rdata_r <= stack_ptr[7:4];
        default:                     rdata_r <= 4'h0;
      endcase
    end else begin
      rdata_r <= 4'h0;
    end
  end

  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      CMS_ST_IDLE: begin
        if (start && tbl_cycles != 3'h1) begin
          state_nxt = CMS_ST_EXEC;
        end
      end
      CMS_ST_EXEC: begin
        if (count_r == 3'h1) begin
          state_nxt = CMS_ST_IDLE;
        end
      end
      default: begin
        state_nxt = CMS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= CMS_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // machine cycle countdown; the accepting cycle is the first machine cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      count_r <= 3'h0;
    end else if (start) begin
      count_r <= tbl_cycles - 3'h1;
    end else if (count_r != 3'h0) begin
      count_r <= count_r - 3'h1;
    end
  end

  // done pulses in the cycle after the last machine cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      done_r <= 1'b0;
    end else begin
      done_r <= (start && tbl_cycles == 3'h1) ||
                (state_r == CMS_ST_EXEC && count_r == 3'h1);
    end
  end

  // refusal pulses, one cycle each
  always_ff @(posedge clk) begin
    if (srst) begin
      illegal_r <= 1'b0;
      range_r   <= 1'b0;
    end else begin
      illegal_r <= refuse_illegal;
      range_r   <= refuse_range;
    end
  end

  // per-instruction figures held until the next accepted instruction
  always_ff @(posedge clk) begin
    if (srst) begin
      push_bytes_r  <= 2'h0;
      pop_bytes_r   <= 2'h0;
      exec_cycles_r <= 3'h0;
    end else if (start) begin
      push_bytes_r  <= tbl_push;
      pop_bytes_r   <= tbl_pop;
      exec_cycles_r <= tbl_cycles;
    end
  end

  // stack pointer moves once, at acceptance, by the mode's frame size
  cms_stack_track u_stack (
    .clk       (clk),
    .srst      (srst),
    .push      (start & tbl_is_call),
    .pop       (start & (op_code == CMS_OP_RETURN)),
    .nbytes    (tbl_is_call ? tbl_push : tbl_pop),
    .stack_ptr (stack_ptr)
  );

  // outputs
  assign op_ready           = (state_r == CMS_ST_IDLE);
  assign exec_busy          = (state_r == CMS_ST_EXEC);
  assign exec_done          = done_r;
  assign exec_illegal       = illegal_r;
  assign exec_range_err     = range_r;
  assign push_bytes         = push_bytes_r;
  assign pop_bytes          = pop_bytes_r;
  assign exec_cycles        = exec_cycles_r;
  assign extended_call_mode = extended;
  assign stack_bank         = stack_bank_select_r[`CMS_SBS_BANK_LSB +: 2];
  assign prog_limit         = limit;
  assign reg_rdata          = rdata_r;

endmodule // cms_call_mode

// >>> hw/cms_regs.svh
// cms_regs.svh - register offsets, field positions, reset values and timing counts
// assumes: included by bare name from the call mode block and its helpers
`ifndef CMS_REGS_SVH
`define CMS_REGS_SVH

// register offsets on the 4-bit register port
`define CMS_ADDR_STACK_BANK_SELECT 4'h0
`define CMS_ADDR_STATUS            4'h1
`define CMS_ADDR_STACK_PTR_LO      4'h2
`define CMS_ADDR_STACK_PTR_HI      4'h3

// stack bank select fields
`define CMS_SBS_MODE_BIT           3
`define CMS_SBS_BANK_LSB           0
`define CMS_SBS_RESET              4'h8

// status fields
`define CMS_STAT_EXTENDED_BIT      0
`define CMS_STAT_ILLEGAL_BIT       1
`define CMS_STAT_RANGE_BIT         2
`define CMS_STAT_BUSY_BIT          3

// stack bytes per call frame
`define CMS_PUSH_LEGACY            2'h2
`define CMS_PUSH_EXTENDED          2'h3

// machine cycles, one machine cycle is one clk
`define CMS_CYC_ABS_LEGACY         3'h3
`define CMS_CYC_ABS_EXTENDED       3'h4
`define CMS_CYC_FAST_LEGACY        3'h2
`define CMS_CYC_FAST_EXTENDED      3'h3
`define CMS_CYC_EXT_CALL           3'h3
`define CMS_CYC_EXT_BRANCH         3'h3
`define CMS_CYC_RETURN             3'h3

// reachable program memory in bytes
`define CMS_PROG_LIMIT_LEGACY      15'h4000
`define CMS_PROG_LIMIT_EXTENDED    15'h6000

// stack pointer reset value, in bytes within the selected bank
`define CMS_STACK_PTR_RESET        8'h00

`endif

// >>> hw/cms_pkg.sv
// cms_pkg.sv - types shared by the call mode block
// assumes: compiled before any cms module
package cms_pkg;

  // instruction classes the decoder hands to this block
  typedef enum logic [2:0] {
    CMS_OP_CALL_ABS   = 3'h0,
    CMS_OP_CALL_FAST  = 3'h1,
    CMS_OP_EXT_CALL   = 3'h2,
    CMS_OP_EXT_BRANCH = 3'h3,
    CMS_OP_RETURN     = 3'h4
  } cms_op_t;

  // execution sequencer states, one-hot
  typedef enum logic [1:0] {
    CMS_ST_IDLE = 2'b01,
    CMS_ST_EXEC = 2'b10
  } cms_state_t;

endpackage

// >>> hw/cms_op_table.sv
// cms_op_table.sv - per-mode lookup of cycles, stack bytes and availability
// assumes: purely combinational, fed from the decode stage of the same clock
`timescale 1ns/1ns
`include "cms_regs.svh"

module cms_op_table (
  // request
  input  wire cms_pkg::cms_op_t op,
  input  wire logic             extended,
  // answer
  output logic [2:0]            cycles,
  output logic [1:0]            push_bytes,
  output logic [1:0]            pop_bytes,
  output logic                  allowed,
  output logic                  is_call
);
  import cms_pkg::*;

  logic [1:0] frame_bytes;

  // a return pops exactly what a call in the same mode pushed
  assign frame_bytes = extended ? `CMS_PUSH_EXTENDED : `CMS_PUSH_LEGACY;

  // table lookup, unknown codes are treated as unavailable
  always_comb begin
    cycles     = 3'h1;
    push_bytes = 2'h0;
    pop_bytes  = 2'h0;
    allowed    = 1'b1;
    is_call    = 1'b0;
    unique case (op)
      CMS_OP_CALL_ABS: begin
        cycles     = extended ? `CMS_CYC_ABS_EXTENDED : `CMS_CYC_ABS_LEGACY;
        push_bytes = frame_bytes;
        is_call    = 1'b1;
      end
      CMS_OP_CALL_FAST: begin
        cycles     = extended ? `CMS_CYC_FAST_EXTENDED : `CMS_CYC_FAST_LEGACY;
        push_bytes = frame_bytes;
        is_call    = 1'b1;
      end
      CMS_OP_EXT_CALL: begin
        cycles     = `CMS_CYC_EXT_CALL;
        push_bytes = frame_bytes;
        allowed    = extended;
        is_call    = 1'b1;
      end
      CMS_OP_EXT_BRANCH: begin
        cycles     = `CMS_CYC_EXT_BRANCH;
        allowed    = extended;
      end
      CMS_OP_RETURN: begin
        cycles     = `CMS_CYC_RETURN;
        pop_bytes  = frame_bytes;
      end
      default: begin
        allowed    = 1'b0;
      end
    endcase
  end

endmodule // cms_op_table

// >>> hw/cms_stack_track.sv
// cms_stack_track.sv - byte-granular stack pointer inside the selected bank
// assumes: push and pop never fire together, both are single-cycle strobes
`timescale 1ns/1ns
`include "cms_regs.svh"

module cms_stack_track (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // stack moves
  input  wire logic       push,
  input  wire logic       pop,
  input  wire logic [1:0] nbytes,
  // state
  output logic [7:0]      stack_ptr
);

  // stack grows downward; wraps silently inside the 256-byte bank window
  always_ff @(posedge clk) begin
    if (srst) begin
      stack_ptr <= `CMS_STACK_PTR_RESET;
    end else if (push) begin
      stack_ptr <= stack_ptr - {6'h00, nbytes};
    end else if (pop) begin
      stack_ptr <= stack_ptr + {6'h00, nbytes};
    end
  end

endmodule // cms_stack_track

// >>> test/cms_call_mode_props.sv
// cms_call_mode_props.sv - port-level assertions for the call mode block
// assumes: bound onto cms_call_mode, one clock, synchronous active-high reset
`timescale 1ns/1ns

module cms_call_mode_props
  import cms_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // register port
  input wire logic [3:0]  reg_addr,
  input wire logic [3:0]  reg_wdata,
  input wire logic        reg_wr,
  // instruction offer
  input wire logic        op_valid,
  input wire cms_op_t     op_code,
  input wire logic [14:0] op_target,
  input wire logic        op_ready,
  // results and mode view
  input wire logic        exec_busy,
  input wire logic        exec_done,
  input wire logic        exec_illegal,
  input wire logic        exec_range_err,
  input wire logic [1:0]  push_bytes,
  input wire logic [1:0]  pop_bytes,
  input wire logic [2:0]  exec_cycles,
  input wire logic        extended_call_mode,
  input wire logic [1:0]  stack_bank,
  input wire logic [14:0] prog_limit
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // a take of an in-range call or branch; mode is sampled at that edge
  wire tk = op_valid && op_ready;
  wire ok = op_target < prog_limit;

  property p_mode;
    reg_wr && reg_addr == 4'h0 |=> extended_call_mode == !$past(reg_wdata[3])
      && stack_bank == $past(reg_wdata[1:0]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode view differs from written value");

  // reset itself is the antecedent, so it must not disable this one
  property p_rst;
    disable iff (1'b0) srst |=> !extended_call_mode && stack_bank == 2'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset did not restore legacy mode");

  property p_lim;
    prog_limit == (extended_call_mode ? 15'h6000 : 15'h4000);
  endproperty
  a_lim: assert property (p_lim) else $error("program limit wrong for mode");

  property p_push;
    tk && ok && (op_code == CMS_OP_CALL_ABS || op_code == CMS_OP_CALL_FAST)
      |=> push_bytes == ($past(extended_call_mode) ? 2'h3 : 2'h2);
  endproperty
  a_push: assert property (p_push) else $error("call push count wrong");

  property p_pop;
    tk && op_code == CMS_OP_RETURN |=> pop_bytes == ($past(extended_call_mode) ? 2'h3 : 2'h2);
  endproperty
  a_pop: assert property (p_pop) else $error("return pop count wrong");

  property p_ill;
    tk && !extended_call_mode && (op_code == CMS_OP_EXT_CALL || op_code == CMS_OP_EXT_BRANCH)
      |=> exec_illegal && !exec_busy && op_ready ##1 !exec_done && !exec_busy;
  endproperty
  a_ill: assert property (p_ill) else $error("extended op ran in legacy mode");

  property p_fast;
    tk && ok && op_code == CMS_OP_CALL_FAST
      |=> exec_cycles == ($past(extended_call_mode) ? 3'h3 : 3'h2);
  endproperty
  a_fast: assert property (p_fast) else $error("fast call cycle count wrong");

  property p_absl;
    tk && ok && !extended_call_mode && op_code == CMS_OP_CALL_ABS
      |=> exec_busy [*2] ##1 (exec_done && !exec_busy);
  endproperty
  a_absl: assert property (p_absl) else $error("legacy absolute call not 3 cycles");

  property p_absx;
    tk && ok && extended_call_mode && op_code == CMS_OP_CALL_ABS
      |=> exec_busy [*3] ##1 (exec_done && !exec_busy);
  endproperty
  a_absx: assert property (p_absx) else $error("extended absolute call not 4 cycles");

  // main scenarios reached
  c_ext: cover property (tk && extended_call_mode);
  c_ill: cover property (exec_illegal);
  c_rng: cover property (exec_range_err);
endmodule // cms_call_mode_props

// >>> test/cms_call_mode_bench.sv
// cms_call_mode_bench.sv - self-checking bench for the call mode block
// assumes: cms_pkg, cms_regs.svh and the design compiled before this file
`timescale 1ns/1ns

module cms_call_mode_bench;
  import cms_pkg::*;

  // design ports
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [3:0]  reg_wdata = 4'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        op_valid = 1'b0;
  cms_op_t     op_code = CMS_OP_CALL_ABS;
  logic [14:0] op_target = 15'h0000;
  logic [3:0]  reg_rdata;
  logic        op_ready, exec_busy, exec_done, exec_illegal, exec_range_err;
  logic [1:0]  push_bytes, pop_bytes, stack_bank;
  logic [2:0]  exec_cycles;
  logic        extended_call_mode;
  logic [14:0] prog_limit;
  logic [7:0]  stack_ptr;
  // model state: register copy and stack pointer kept as plain integers
  int          stack_bank_select = 8;
  int          sp = 0;
  int          fail_count = 0;
  int          checks_done = 0;
  logic [31:0] seed = 32'h1117;

  always #4 clk = ~clk;

  cms_call_mode u_dut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_valid(op_valid),
    .op_code(op_code), .op_target(op_target), .op_ready(op_ready), .exec_busy(exec_busy),
    .exec_done(exec_done), .exec_illegal(exec_illegal), .exec_range_err(exec_range_err),
    .push_bytes(push_bytes), .pop_bytes(pop_bytes), .exec_cycles(exec_cycles),
    .extended_call_mode(extended_call_mode), .stack_bank(stack_bank),
    .prog_limit(prog_limit), .stack_ptr(stack_ptr));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] got, input int e);
    checks_done++;
    if (got !== 16'(e)) begin
      fail_count++;
      $display("BAD %s expected %0h seen %0h", n, e, got);
    end
  endtask

  // one-cycle bus strobes, released on the following edge
  task automatic wr(input logic [3:0] a, input logic [3:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a == 4'h0) stack_bank_select = d;
  endtask

  task automatic rd(input logic [3:0] a, input int e, input string n);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(n, reg_rdata, e);
  endtask

  // offer one instruction, time it to its pulse and compare with the model
  task automatic op(input cms_op_t c, input logic [14:0] t);
    int n;
    int nx;
    int pb;
    bit ext;
    bit ill;
    bit rng;
    ext = (stack_bank_select & 8) == 0;
    pb = ext ? 3 : 2;
    ill = !ext && (c == CMS_OP_EXT_CALL || c == CMS_OP_EXT_BRANCH);
    rng = !ill && c != CMS_OP_RETURN && t >= (ext ? 24576 : 16384);
    nx = c == CMS_OP_CALL_ABS ? pb + 1 : (c == CMS_OP_CALL_FAST ? pb : 3);
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= c;
    op_target <= t;
    @(posedge clk);
    op_valid <= 1'b0;
    // the taking cycle is machine cycle one; refusal pulses stand only in the next cycle
    n = 1;
    #1 chk("busy", exec_busy, !(ill || rng));
    while (!(exec_done || exec_illegal || exec_range_err) && n < 9) begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 9) begin
      fail_count++;
      summarize();
    end
    chk("done", exec_done, !(ill || rng));
    chk("ready", op_ready, 1);
    chk("illegal", exec_illegal, ill);
    chk("range", exec_range_err, rng);
    if (!ill && !rng) begin
      chk("latency", 16'(n), nx);
      chk("cycles", exec_cycles, nx);
      if (c == CMS_OP_RETURN) begin
        chk("pop", pop_bytes, pb);
        sp = (sp + pb) & 255;
      end else if (c != CMS_OP_EXT_BRANCH) begin
        chk("push", push_bytes, pb);
        sp = (sp - pb) & 255;
      end
      chk("stack_ptr", stack_ptr, sp);
    end
  endtask

  initial begin
    int b;
    int lim;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rd(4'h0, 8, "sbs reset");
    chk("mode reset", extended_call_mode, 0);
    rd(4'hf, 0, "unmapped");
    // even passes legacy, odd passes extended, random stack bank each time
    for (int m = 0; m < 6; m++) begin
      b = int'(xs() % 4);
      lim = (m % 2) ? 24576 : 16384;
      wr(4'h0, 4'(((m % 2) ? 0 : 8) | b));
      #1 chk("mode", extended_call_mode, m % 2);
      chk("bank", stack_bank, b);
      chk("limit", prog_limit, lim);
      rd(4'h0, stack_bank_select, "sbs");
      for (int k = 0; k < 5; k++) op(cms_op_t'(k), 15'(xs() % lim));
      op(CMS_OP_CALL_ABS, 15'(lim - 1));
      op(CMS_OP_CALL_FAST, 15'(lim));
    end
    // sticky refusal flag seen in status and cleared by writing one
    wr(4'h0, 4'h8);
    wr(4'h1, 4'h6);
    op(CMS_OP_EXT_BRANCH, 15'h0000);
    rd(4'h1, 2, "status");
    wr(4'h1, 4'h2);
    rd(4'h1, 0, "status clear");
    // second reset in mid-run after switching to extended mode
    wr(4'h0, 4'h3);
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    stack_bank_select = 8;
    sp = 0;
    rd(4'h0, 8, "sbs rereset");
    chk("stack_ptr rereset", stack_ptr, 0);
    op(CMS_OP_CALL_ABS, 15'h0100);
    rd(4'h2, sp & 15, "sp lo");
    rd(4'h3, (sp >> 4) & 15, "sp hi");
    summarize();
  end
endmodule // cms_call_mode_bench

bind cms_call_mode cms_call_mode_props u_props (.clk(clk), .srst(srst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .op_valid(op_valid), .op_code(op_code),
  .op_target(op_target), .op_ready(op_ready), .exec_busy(exec_busy), .exec_done(exec_done),
  .exec_illegal(exec_illegal), .exec_range_err(exec_range_err), .push_bytes(push_bytes),
  .pop_bytes(pop_bytes), .exec_cycles(exec_cycles), .extended_call_mode(extended_call_mode),
  .stack_bank(stack_bank), .prog_limit(prog_limit));
